// [hw/swb_params.svh]
`ifndef SWB_PARAMS_SVH
`define SWB_PARAMS_SVH

// Command codes of the two byte commands.
`define SWB_CMD_WRITE_BYTE 8'ha5
`define SWB_CMD_READ_BYTE  8'h96

// Clock period in picoseconds (40 MHz).
`define SWB_CLK_PS 25000

// Latest start of line activity after the triggering SCL edge.
`define SWB_T_START_MAX_PS 262500
`define SWB_START_MAX_CYC ((`SWB_T_START_MAX_PS) / (`SWB_CLK_PS))

// Slot timing in nanoseconds, standard and overdrive speed.
`define SWB_T_SLOT_STD_NS 65000
`define SWB_T_SLOT_OD_NS  10000
`define SWB_T_LOW1_STD_NS 8000
`define SWB_T_LOW1_OD_NS  1000
`define SWB_T_LOW0_STD_NS 60000
`define SWB_T_LOW0_OD_NS  7500
`define SWB_T_MSR_STD_NS  14000
`define SWB_T_MSR_OD_NS   2000
`define SWB_T_ACTIVE_PU_NS 2000

// Nanoseconds to cycles, rounded up (least times).
`define SWB_NS2CYC(ns) ((((ns) * 1000) + (`SWB_CLK_PS) - 1) / (`SWB_CLK_PS))

// Slot engine counts.
`define SWB_BITS_PER_BYTE 8
`define SWB_LAST_BIT      3'h7

`endif

// [hw/swb_pkg.sv]
package swb_pkg;

  // Command decoder states.
  typedef enum logic [1:0] {
    SWB_IDLE,
    SWB_WAIT_DATA,
    SWB_WAIT_ACK,
    SWB_DISCARD
  } swb_cmd_state_e;

  typedef logic [15:0] swb_cnt_t;

endpackage

// [hw/swb_byte_xfer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "swb_params.svh"

// Small FIFO with a registered output stage.
module swb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             clk_in,
  input  wire logic             reset_n_in,
  // Fill side.
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Drain side.
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // Memory pops whenever the output stage is free or being drained.
  // The output stage counts toward capacity, so at most DEPTH words are held.
  assign in_ready_out = ((count_r + (AW+1)'(out_valid_out)) < (AW+1)'(DEPTH));
  assign push         = in_valid_in && in_ready_out;
  assign pop          = (count_r != '0) && (!out_valid_out || out_ready_in);

  // Storage array and pointers.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Array write, no reset needed.
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  // Output stage.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      out_valid_out <= 1'b0;
      out_data_out  <= '0;
    end else if (pop) begin
      out_valid_out <= 1'b1;
      out_data_out  <= mem_r[rd_ptr_r];
    end else if (out_ready_in) begin
      out_valid_out <= 1'b0;
    end
  end
endmodule

// Byte write and byte read engine of the single-wire bridge.
module swb_byte_xfer #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset.
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  // Events from the host-side byte receiver.
  input  wire logic       code_valid_in,
  input  wire logic [7:0] code_in,
  input  wire logic       data_valid_in,
  input  wire logic [7:0] data_in,
  input  wire logic       ack_fall_in,
  output logic            cmd_ack_out,
  output logic            rptr_status_out,
  // Configuration.
  input  wire logic       overdrive_speed_select_in,
  input  wire logic       strong_pullup_enable_in,
  input  wire logic       active_pullup_enable_in,
  // Status and read data.
  output logic            line_busy_flag_out,
  output logic [7:0]      read_data_out,
  output logic            rdq_valid_out,
  output logic [7:0]      rdq_data_out,
  input  wire logic       rdq_ready_in,
  // Single-wire line, driven low while the enable is high.
  input  wire logic       line_in,
  output logic            line_out,
  output logic            line_oe_out,
  output logic            active_pullup_out,
  output logic            strong_pullup_out
);
  localparam swb_pkg::swb_cnt_t ACTIVE_PU_CYC = 16'(`SWB_NS2CYC(`SWB_T_ACTIVE_PU_NS));

  swb_pkg::swb_cmd_state_e st_r;
  logic       go_r;
  logic       go_rd_r;
  logic [7:0] go_data_r;
  logic       is_rd_r;
  logic       od_r;
  logic       strong_en_r;
  logic       active_en_r;
  logic [7:0] sh_r;
  logic [2:0] bit_r;
  logic       samp_r;
  logic       push_r;
  logic       q_ready;
  swb_pkg::swb_cnt_t cyc_r;
  swb_pkg::swb_cnt_t active_cnt_r;
  swb_pkg::swb_cnt_t cyc_nxt;
  logic       busy_nxt;
  logic [7:0] sh_nxt;
  logic [2:0] bit_nxt;
  logic       od_nxt;
  logic       rd_nxt;
  logic       slot_end;

  // Slot period for the selected speed.
  function automatic swb_pkg::swb_cnt_t slot_cyc(input logic od);
    slot_cyc = od ? 16'(`SWB_NS2CYC(`SWB_T_SLOT_OD_NS)) : 16'(`SWB_NS2CYC(`SWB_T_SLOT_STD_NS));
  endfunction

  // Low time of a slot for the bit value and speed.
  function automatic swb_pkg::swb_cnt_t low_cyc(input logic od, input logic one);
    if (one) begin
      low_cyc = od ? 16'(`SWB_NS2CYC(`SWB_T_LOW1_OD_NS)) : 16'(`SWB_NS2CYC(`SWB_T_LOW1_STD_NS));
    end else begin
      low_cyc = od ? 16'(`SWB_NS2CYC(`SWB_T_LOW0_OD_NS)) : 16'(`SWB_NS2CYC(`SWB_T_LOW0_STD_NS));
    end
  endfunction

  // Sample point of a read slot.
  function automatic swb_pkg::swb_cnt_t msr_cyc(input logic od);
    msr_cyc = od ? 16'(`SWB_NS2CYC(`SWB_T_MSR_OD_NS)) : 16'(`SWB_NS2CYC(`SWB_T_MSR_STD_NS));
  endfunction

  // Command decoder: acceptance, refusal and start requests.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st_r            <= swb_pkg::SWB_IDLE;
      cmd_ack_out     <= 1'b0;
      rptr_status_out <= 1'b0;
      go_r            <= 1'b0;
      go_rd_r         <= 1'b0;
      go_data_r       <= '0;
    end else begin
      go_r            <= 1'b0;
      rptr_status_out <= 1'b0;
      unique case (st_r)
        swb_pkg::SWB_IDLE: begin
          if (code_valid_in) begin
            if (code_in == `SWB_CMD_WRITE_BYTE) begin
              cmd_ack_out <= !line_busy_flag_out;
              st_r <= line_busy_flag_out ? swb_pkg::SWB_DISCARD : swb_pkg::SWB_WAIT_DATA;
            end else if (code_in == `SWB_CMD_READ_BYTE && !line_busy_flag_out && q_ready) begin
              cmd_ack_out     <= 1'b1;
              rptr_status_out <= 1'b1;
              st_r            <= swb_pkg::SWB_WAIT_ACK;
            end else begin
              cmd_ack_out <= 1'b0;
            end
          end
        end
        swb_pkg::SWB_WAIT_DATA: begin
          if (data_valid_in) begin
            cmd_ack_out     <= 1'b1;
            rptr_status_out <= 1'b1;
            go_r            <= 1'b1;
            go_rd_r         <= 1'b0;
            go_data_r       <= data_in;
            st_r            <= swb_pkg::SWB_IDLE;
          end
        end
        swb_pkg::SWB_WAIT_ACK: begin
          if (ack_fall_in) begin
            go_r    <= 1'b1;
            go_rd_r <= 1'b1;
            st_r    <= swb_pkg::SWB_IDLE;
          end
        end
        swb_pkg::SWB_DISCARD: begin
          if (data_valid_in) begin
            cmd_ack_out <= 1'b0;
            st_r        <= swb_pkg::SWB_IDLE;
          end
        end
      endcase
    end
  end

  // Next-state values of the slot engine.
  always_comb begin
    slot_end = line_busy_flag_out && (cyc_r == slot_cyc(od_r) - 16'h1);
    busy_nxt = line_busy_flag_out;
    cyc_nxt  = cyc_r + 16'h1;
    sh_nxt   = sh_r;
    bit_nxt  = bit_r;
    od_nxt   = od_r;
    rd_nxt   = is_rd_r;
    if (go_r) begin
      busy_nxt = 1'b1;
      cyc_nxt  = '0;
      bit_nxt  = '0;
      sh_nxt   = go_rd_r ? 8'hff : go_data_r;
      od_nxt   = overdrive_speed_select_in;
      rd_nxt   = go_rd_r;
    end else if (slot_end) begin
      cyc_nxt = '0;
      bit_nxt = bit_r + 3'h1;
      sh_nxt  = {is_rd_r ? samp_r : 1'b1, sh_r[7:1]};
      if (bit_r == `SWB_LAST_BIT) begin
        busy_nxt = 1'b0;
      end
    end else if (!line_busy_flag_out) begin
      cyc_nxt = cyc_r;
    end
  end

  // Slot engine state.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      line_busy_flag_out <= 1'b0;
      cyc_r              <= '0;
      bit_r              <= '0;
      sh_r               <= '0;
      od_r               <= 1'b0;
      is_rd_r            <= 1'b0;
      strong_en_r        <= 1'b0;
      active_en_r        <= 1'b0;
    end else begin
      line_busy_flag_out <= busy_nxt;
      cyc_r              <= cyc_nxt;
      bit_r              <= bit_nxt;
      sh_r               <= sh_nxt;
      od_r               <= od_nxt;
      is_rd_r            <= rd_nxt;
      if (go_r) begin
        strong_en_r <= strong_pullup_enable_in && !go_rd_r;
        active_en_r <= active_pullup_enable_in;
      end
    end
  end

  // Line drive: low for the bit's low time at the start of each slot.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      line_oe_out <= 1'b0;
      line_out    <= 1'b0;
    end else begin
      line_out    <= 1'b0;
      line_oe_out <= busy_nxt && (cyc_nxt < low_cyc(od_nxt, rd_nxt | sh_nxt[0]));
    end
  end

  // Line sample at the read sample point.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      samp_r <= 1'b0;
    end else if (line_busy_flag_out && cyc_r == msr_cyc(od_r)) begin
      samp_r <= line_in;
    end
  end

  // Active pullup pulse after each release of the line.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      active_cnt_r      <= '0;
      active_pullup_out <= 1'b0;
    end else begin
      if (line_oe_out && !(busy_nxt && (cyc_nxt < low_cyc(od_nxt, rd_nxt | sh_nxt[0]))) && active_en_r) begin
        active_cnt_r      <= ACTIVE_PU_CYC;
        active_pullup_out <= 1'b1;
      end else if (active_cnt_r > 16'h1) begin
        active_cnt_r <= active_cnt_r - 16'h1;
      end else begin
        active_cnt_r      <= '0;
        active_pullup_out <= 1'b0;
      end
    end
  end

  // Strong pullup held after a byte write until the next start or disable.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strong_pullup_out <= 1'b0;
    end else if (go_r || !strong_pullup_enable_in) begin
      strong_pullup_out <= 1'b0;
    end else if (slot_end && bit_r == `SWB_LAST_BIT && strong_en_r) begin
      strong_pullup_out <= 1'b1;
    end
  end

  // Read result into the read data register and the FIFO.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      read_data_out <= '0;
      push_r        <= 1'b0;
    end else begin
      push_r <= 1'b0;
      if (slot_end && bit_r == `SWB_LAST_BIT && is_rd_r) begin
        read_data_out <= sh_nxt;
        push_r        <= 1'b1;
      end
    end
  end

  swb_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_rdq (
    .clk_in        (core_clk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (push_r),
    .in_data_in    (read_data_out),
    .in_ready_out  (q_ready),
    .out_valid_out (rdq_valid_out),
    .out_data_out  (rdq_data_out),
    .out_ready_in  (rdq_ready_in)
  );

  // Helper: length of each busy period and of each slot's low time.
  swb_pkg::swb_cnt_t busy_len_r;
  swb_pkg::swb_cnt_t low_len_r;
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_len_r <= '0;
      low_len_r  <= '0;
    end else begin
      busy_len_r <= line_busy_flag_out ? busy_len_r + 16'h1 : '0;
      low_len_r  <= line_oe_out ? low_len_r + 16'h1 : '0;
    end
  end

  sequence s_write_taken;
    st_r == swb_pkg::SWB_WAIT_DATA && data_valid_in;
  endsequence

  sequence s_read_taken;
    st_r == swb_pkg::SWB_WAIT_ACK && ack_fall_in;
  endsequence

  property p_write_start;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    s_write_taken |-> ##2 (line_busy_flag_out && line_oe_out);
  endproperty
  a_write_start: assert property (p_write_start) else $error("write did not start in time");

  property p_read_start;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    s_read_taken |-> ##2 (line_busy_flag_out && line_oe_out);
  endproperty
  a_read_start: assert property (p_read_start) else $error("read did not start in time");

  property p_busy_len;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    $fell(line_busy_flag_out) |-> busy_len_r == 16'(`SWB_BITS_PER_BYTE) * slot_cyc(od_r);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length is not eight slots");

  property p_write_nack;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    code_valid_in && code_in == `SWB_CMD_WRITE_BYTE && line_busy_flag_out && st_r == swb_pkg::SWB_IDLE
      |=> !cmd_ack_out && st_r == swb_pkg::SWB_DISCARD;
  endproperty
  a_write_nack: assert property (p_write_nack) else $error("busy write code was acknowledged");

  property p_discard;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    st_r == swb_pkg::SWB_DISCARD && data_valid_in
      |=> !cmd_ack_out && !go_r && $stable(go_data_r) && st_r == swb_pkg::SWB_IDLE;
  endproperty
  a_discard: assert property (p_discard) else $error("discarded write started");

  property p_read_nack;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    code_valid_in && code_in == `SWB_CMD_READ_BYTE && line_busy_flag_out && st_r == swb_pkg::SWB_IDLE
      |=> !cmd_ack_out && st_r == swb_pkg::SWB_IDLE;
  endproperty
  a_read_nack: assert property (p_read_nack) else $error("busy read code was acknowledged");

  property p_lsb_first;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    s_write_taken |-> ##2 sh_r[0] == $past(data_in[0], 2);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("first bit is not the LSB");

  property p_read_low;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    is_rd_r && $fell(line_oe_out) |-> low_len_r == low_cyc(od_r, 1'b1);
  endproperty
  a_read_low: assert property (p_read_low) else $error("read slot low time wrong");

  property p_read_store;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    slot_end && is_rd_r && bit_r == `SWB_LAST_BIT |=> push_r && read_data_out == $past(sh_nxt);
  endproperty
  a_read_store: assert property (p_read_store) else $error("read byte not stored");

  property p_no_strong_read;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    is_rd_r && line_busy_flag_out |-> !strong_en_r && !strong_pullup_out;
  endproperty
  a_no_strong_read: assert property (p_no_strong_read) else $error("strong pullup on read");

  property p_rptr;
    @(posedge core_clk_in) disable iff (!reset_n_in)
    s_write_taken |=> rptr_status_out && cmd_ack_out;
  endproperty
  a_rptr: assert property (p_rptr) else $error("pointer not reported");
endmodule

`default_nettype wire

// [dv/swb_line_slave.sv]
`timescale 1ns/1ps
`default_nettype none

// Behavioural slave on the single-wire line: decodes slots and answers reads.
module swb_line_slave (
  // Clock and line view.
  input  wire logic       clk_in,
  input  wire logic       oe_in,
  input  wire logic       od_in,
  // Read answer.
  input  wire logic       resp_en_in,
  input  wire logic [7:0] resp_in,
  output logic            pull_low_out,
  // Decoded traffic.
  output logic [7:0]      rx_out,
  output int              nbits_out
);
  int   len;
  int   hold;
  logic oe_d;

  initial begin
    len = 0;
    hold = 0;
    oe_d = 1'b0;
    rx_out = 8'h00;
    nbits_out = 0;
  end

  // Short low time means a one, long low time a zero; bits arrive first in bit 0.
  always @(posedge clk_in) begin
    oe_d <= oe_in;
    if (oe_in) begin
      len <= len + 1;
    end
    if (oe_in && !oe_d) begin
      len <= 1;
      if (resp_en_in && !resp_in[nbits_out % 8]) begin
        hold <= od_in ? 100 : 800;
      end
    end else if (hold > 0) begin
      hold <= hold - 1;
    end
    if (!oe_in && oe_d) begin
      rx_out <= {(len < (od_in ? 170 : 1360)), rx_out[7:1]};
      nbits_out <= nbits_out + 1;
    end
  end

  // The line is pulled up, so a released slave simply stops pulling.
  assign pull_low_out = (hold > 0);
endmodule

`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "swb_params.svh"

module testbench;
  localparam int DEPTH = 4;
  logic       core_clk_in, reset_n_in, code_valid, data_valid, ack_fall;
  logic       od, strong_en, active_en, rdq_ready, resp_en, busy_d, active_d;
  logic [7:0] code, data, resp;
  wire logic  cmd_ack, rptr, busy, line_o, oe, active_o, strong_o, rdq_valid, pull_low, line_w;
  wire logic [7:0] rd_data, rdq_data, rx;
  int         nbits, fails, n_checks, cycles, rise, fall, trig, nrptr, napu, n0, t0;
  logic [7:0] vals [DEPTH] = '{8'h5a, 8'h81, 8'hc3, 8'h0f};

  swb_byte_xfer #(.FIFO_DEPTH(DEPTH)) dut (
    .core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
    .code_valid_in(code_valid), .code_in(code), .data_valid_in(data_valid), .data_in(data),
    .ack_fall_in(ack_fall), .cmd_ack_out(cmd_ack), .rptr_status_out(rptr),
    .overdrive_speed_select_in(od), .strong_pullup_enable_in(strong_en), .active_pullup_enable_in(active_en),
    .line_busy_flag_out(busy), .read_data_out(rd_data), .rdq_valid_out(rdq_valid),
    .rdq_data_out(rdq_data), .rdq_ready_in(rdq_ready), .line_in(line_w), .line_out(line_o),
    .line_oe_out(oe), .active_pullup_out(active_o), .strong_pullup_out(strong_o));

  swb_line_slave slave (
    .clk_in(core_clk_in), .oe_in(oe), .od_in(od), .resp_en_in(resp_en), .resp_in(resp),
    .pull_low_out(pull_low), .rx_out(rx), .nbits_out(nbits));

  // Open-drain line with pull-up.
  assign line_w = (oe ? line_o : 1'b1) & !pull_low;

  // Clock generation.
  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  // Cycle count, busy edges, pointer and pullup pulses, and the hang limit.
  always @(posedge core_clk_in) begin
    cycles++;
    busy_d <= busy;
    active_d <= active_o;
    if (busy === 1'b1 && busy_d !== 1'b1) rise = cycles;
    if (busy === 1'b0 && busy_d === 1'b1) fall = cycles;
    if (rptr === 1'b1) nrptr++;
    if (active_o === 1'b1 && active_d !== 1'b1) napu++;
    if (cycles >= 80000) begin
      fails++;
      summarize();
    end
  end

  // Compares two values and reports a difference.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Sends one code or data byte event; the answer is settled on return.
  task automatic send(input logic [7:0] b, input logic is_data);
    @(negedge core_clk_in);
    if (is_data) begin
      data = b;
      data_valid = 1'b1;
    end else begin
      code = b;
      code_valid = 1'b1;
    end
    trig = cycles;
    @(negedge core_clk_in);
    code_valid = 1'b0;
    data_valid = 1'b0;
    @(negedge core_clk_in);
  endtask

  // Marks the falling clock edge of the acknowledge bit after a read code.
  task automatic ackfall();
    @(negedge core_clk_in);
    ack_fall = 1'b1;
    trig = cycles;
    @(negedge core_clk_in);
    ack_fall = 1'b0;
  endtask

  // Waits for the transfer to start and end, then checks its start, length and end.
  task automatic finish_op(input int slot, input int t);
    int k;
    k = 0;
    while (busy !== 1'b1 && k < 12) begin
      @(negedge core_clk_in);
      k++;
    end
    while (busy !== 1'b0 && k < 30000) begin
      @(negedge core_clk_in);
      k++;
    end
    // One more edge so that the falling busy edge has been recorded.
    @(negedge core_clk_in);
    check(16'(k < 30000), 16'h1);
    check(16'(rise > t && rise - t <= 11), 16'h1);
    check(16'((fall - rise >= 8 * slot) && (fall - rise <= 8 * slot + 2)), 16'h1);
    check(16'(fall > rise && fall - t <= 8 * slot + 11), 16'h1);
  endtask

  // Takes one byte out of the read queue.
  task automatic drain_one(input logic [7:0] exp);
    int k;
    k = 0;
    while (rdq_valid !== 1'b1 && k < 8) begin
      @(negedge core_clk_in);
      k++;
    end
    check(16'(rdq_data), 16'(exp));
    rdq_ready = 1'b1;
    @(negedge core_clk_in);
    rdq_ready = 1'b0;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Main sequence of tests.
  initial begin
    {code_valid, data_valid, ack_fall, od, rdq_ready, resp_en} = 6'h00;
    {code, data, resp} = 24'h000000;
    {strong_en, active_en} = 2'b11;
    {fails, n_checks, cycles, nrptr, napu, rise, fall, trig} = '0;
    reset_n_in = 1'b0;
    repeat (3) @(negedge core_clk_in);
    reset_n_in = 1'b1;
    // Standard write with both pullups, refused commands while busy.
    n0 = nbits;
    send(`SWB_CMD_WRITE_BYTE, 1'b0);
    check(16'(cmd_ack), 16'h1);
    send(8'h3c, 1'b1);
    t0 = trig;
    check(16'(cmd_ack), 16'h1);
    repeat (100) @(negedge core_clk_in);
    send(`SWB_CMD_WRITE_BYTE, 1'b0);
    check(16'(cmd_ack), 16'h0);
    send(8'hff, 1'b1);
    check(16'(cmd_ack), 16'h0);
    send(`SWB_CMD_READ_BYTE, 1'b0);
    check(16'(cmd_ack), 16'h0);
    finish_op(2600, t0);
    check(16'(rx), 16'h003c);
    check(16'(nbits - n0), 16'h8);
    check(16'(strong_o), 16'h1);
    check(16'(napu > 0), 16'h1);
    check(16'(nrptr), 16'h1);
    $display("test write_std done");
    // Standard read; strong pullup must not stay on.
    resp = vals[0];
    resp_en = 1'b1;
    send(`SWB_CMD_READ_BYTE, 1'b0);
    check(16'(cmd_ack), 16'h1);
    ackfall();
    finish_op(2600, trig);
    check(16'(strong_o), 16'h0);
    check(16'(rd_data), 16'(vals[0]));
    check(16'(rx), 16'h00ff);
    check(16'(nrptr), 16'h2);
    $display("test read_std done");
    // Overdrive write with pullups off.
    {od, strong_en, active_en, resp_en} = 4'b1000;
    napu = 0;
    send(`SWB_CMD_WRITE_BYTE, 1'b0);
    send(8'hc6, 1'b1);
    finish_op(400, trig);
    check(16'(rx), 16'h00c6);
    check(16'(napu), 16'h0);
    check(16'(strong_o), 16'h0);
    $display("test write_od done");
    // Overdrive reads until the queue refuses, then drain it in order.
    resp_en = 1'b1;
    for (int i = 1; i < DEPTH; i++) begin
      resp = vals[i];
      send(`SWB_CMD_READ_BYTE, 1'b0);
      check(16'(cmd_ack), 16'h1);
      ackfall();
      finish_op(400, trig);
      check(16'(rd_data), 16'(vals[i]));
    end
    send(`SWB_CMD_READ_BYTE, 1'b0);
    check(16'(cmd_ack), 16'h0);
    for (int i = 0; i < DEPTH; i++) begin
      drain_one(vals[i]);
    end
    repeat (4) @(negedge core_clk_in);
    check(16'(rdq_valid), 16'h0);
    $display("test read_queue done");
    summarize();
  end
endmodule

`default_nettype wire
